// >>> bst_pkg.sv
`default_nettype none
package bst_pkg;

    // ------------------------------------------------------------------
    // chain geometry and instruction codes
    // ------------------------------------------------------------------
    localparam int          CHAIN_LEN   = 158;
    localparam int          HEAD_LEN    = 126;
    localparam int          TAIL_LEN    = 32;
    localparam int          IR_LEN      = 3;
    localparam int          ID_LEN      = 32;

    localparam logic [2:0]  IR_EXTEST   = 3'h0;
    localparam logic [2:0]  IR_INTEST   = 3'h1;
    localparam logic [2:0]  IR_SAMPLE   = 3'h2;
    localparam logic [2:0]  IR_IDCODE   = 3'h3;
    localparam logic [2:0]  IR_BYPASS   = 3'h7;
    localparam logic [2:0]  IR_CAPTURE  = 3'h1;
    localparam logic        ID_FIXED_ONE = 1'h1;

    // ------------------------------------------------------------------
    // cell roles: 1 marks a data-in cell, 0 a drive or enable cell
    // ------------------------------------------------------------------
    localparam logic        PAT_IN      = 1'h1;
    localparam logic        PAT_OUT1    = 1'h0;
    localparam logic [1:0]  PAT_OUT     = 2'h0;
    localparam logic [2:0]  PAT_BIDIR   = 3'h4;

    // trailing single cell is a spare drive cell closing the head
    localparam logic [HEAD_LEN-1:0] HEAD_IS_INPUT = {
        PAT_IN, PAT_IN, PAT_IN, PAT_IN, PAT_IN, PAT_OUT, PAT_BIDIR, PAT_OUT1, PAT_IN, PAT_OUT,
        {16{PAT_BIDIR}}, PAT_IN, PAT_IN, {2{PAT_BIDIR}}, {8{PAT_OUT}}, {3{PAT_BIDIR}}, PAT_IN,
        {7{PAT_OUT}}, PAT_BIDIR, {6{PAT_OUT}}, PAT_OUT1};

    localparam logic [TAIL_LEN-1:0] TAIL_IS_INPUT = {
        PAT_OUT, PAT_BIDIR, PAT_BIDIR, PAT_IN, PAT_BIDIR, PAT_BIDIR, PAT_BIDIR, PAT_BIDIR,
        PAT_OUT1, PAT_IN, PAT_IN, PAT_OUT, PAT_BIDIR, PAT_IN, PAT_OUT};

    localparam logic [CHAIN_LEN-1:0] CELL_IS_INPUT = {HEAD_IS_INPUT, TAIL_IS_INPUT};

    // ------------------------------------------------------------------
    // initial cell values
    // ------------------------------------------------------------------
    localparam logic [HEAD_LEN-1:0] HEAD_INIT = {
        1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 2'h0, 3'h0, 1'h0, 1'h0, 2'h1,
        3'h3, 3'h6, 3'h0, 3'h2, 3'h0, 3'h1, 3'h4, 91'h0};
    localparam logic [TAIL_LEN-1:0]  TAIL_INIT = 32'h0;
    localparam logic [CHAIN_LEN-1:0] BSR_INIT  = {HEAD_INIT, TAIL_INIT};

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    // tail cells, first field nearest the serial input
    typedef struct packed {
        logic [1:0] data_bit_14;
        logic [2:0] data_bit_15;
        logic [2:0] tx_dma_request_a;
        logic       dma_acknowledge_a;
        logic [2:0] rx_dma_request_a;
        logic [2:0] rx_dma_request_b;
        logic [2:0] tx_dma_request_b;
        logic [2:0] dma_acknowledge_b;
        logic       request_to_send_b;
        logic       receive_data_b;
        logic       receive_clock_b;
        logic [1:0] transmit_data_b;
        logic [2:0] transmit_clock_b;
        logic       carrier_detect_b;
        logic [1:0] address_strobe_out;
    } bst_tail_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } bst_jtag_t;

    localparam bst_jtag_t JTAG_RESET = 4'h6;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } bst_state_t;

endpackage : bst_pkg
`default_nettype wire

// >>> bst_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bst_sync
    import bst_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      rst_n,
    input  wire bst_jtag_t async_in,
    output var  bst_jtag_t sync_out
);

    // ------------------------------------------------------------------
    // two-stage synchroniser per test pin
    // ------------------------------------------------------------------
    bst_jtag_t meta;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta     <= JTAG_RESET;
            sync_out <= JTAG_RESET;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : bst_sync
`default_nettype wire

// >>> bst_tap_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module bst_tap_fsm
    import bst_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       step,
    input  wire logic       tms,
    input  wire logic       trst_n,
    output var  bst_state_t state
);

    // ------------------------------------------------------------------
    // sixteen-state controller, one step per test clock rise
    // ------------------------------------------------------------------
    bst_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            TLR:     next_state = tms ? TLR    : RTI;
            RTI:     next_state = tms ? SEL_DR : RTI;
            SEL_DR:  next_state = tms ? SEL_IR : CAP_DR;
            CAP_DR:  next_state = tms ? EX1_DR : SH_DR;
            SH_DR:   next_state = tms ? EX1_DR : SH_DR;
            EX1_DR:  next_state = tms ? UPD_DR : PA_DR;
            PA_DR:   next_state = tms ? EX2_DR : PA_DR;
            EX2_DR:  next_state = tms ? UPD_DR : SH_DR;
            UPD_DR:  next_state = tms ? SEL_DR : RTI;
            SEL_IR:  next_state = tms ? TLR    : CAP_IR;
            CAP_IR:  next_state = tms ? EX1_IR : SH_IR;
            SH_IR:   next_state = tms ? EX1_IR : SH_IR;
            EX1_IR:  next_state = tms ? UPD_IR : PA_IR;
            PA_IR:   next_state = tms ? EX2_IR : PA_IR;
            EX2_IR:  next_state = tms ? UPD_IR : SH_IR;
            UPD_IR:  next_state = tms ? SEL_DR : RTI;
            default: next_state = TLR;
        endcase
    end

    // test reset overrides any step
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= TLR;
        end else if (!trst_n) begin
            state <= TLR;
        end else if (step) begin
            state <= next_state;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_trst_forces_reset: assert property (!trst_n |=> state == TLR)
        else $error("test reset did not force reset state");
    chk_idle_holds_state: assert property (!step && trst_n |=> $stable(state))
        else $error("state moved without a test clock step");
    chk_tms_high_holds: assert property (step && trst_n && tms && state == TLR |=> state == TLR)
        else $error("mode select high left reset state");

endmodule : bst_tap_fsm
`default_nettype wire

// >>> bst_tap.sv
`timescale 1ns/1ps
`default_nettype none
module bst_tap
    import bst_pkg::*;
#(
    parameter logic [3:0]  ID_VERSION = 4'h1,   // arbitrary value
    parameter logic [15:0] ID_PART    = 16'hA5C3, // arbitrary value
    parameter logic [10:0] ID_MAKER   = 11'h2B4 // arbitrary value
) (
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic                tck,
    input  wire logic                tms,
    input  wire logic                tdi,
    input  wire logic                trst_n,
    output var  logic                tdo,
    output var  logic                tdo_oe,
    input  wire logic [HEAD_LEN-1:0] head_sys_in,
    output var  logic [HEAD_LEN-1:0] head_sys_out,
    input  wire bst_tail_t           tail_sys_in,
    output var  bst_tail_t           tail_sys_out
);

    // ------------------------------------------------------------------
    // pin sampling and test clock edges
    // ------------------------------------------------------------------
    bst_jtag_t              pins_async;
    bst_jtag_t              pins_s;
    logic                   tck_prev;
    logic                   tck_rise;
    logic                   tck_fall;
    logic                   tdi_s;
    bst_state_t             state;

    assign pins_async = {tck, tms, tdi, trst_n};

    bst_sync u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in (pins_async),
        .sync_out (pins_s)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tck_prev <= 1'h0;
        end else begin
            tck_prev <= pins_s.tck;
        end
    end

    // tms and tdi share the synchroniser latency of tck, so they stay aligned
    assign tck_rise = pins_s.tck & ~tck_prev;
    assign tck_fall = ~pins_s.tck & tck_prev;
    assign tdi_s    = pins_s.tdi;

    bst_tap_fsm u_fsm (
        .clock  (clock),
        .rst_n  (rst_n),
        .step   (tck_rise),
        .tms    (pins_s.tms),
        .trst_n (pins_s.trst_n),
        .state  (state)
    );

    // ------------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------------
    logic [IR_LEN-1:0]      ir;
    logic [IR_LEN-1:0]      ir_shift;
    logic                   sel_extest;
    logic                   sel_intest;
    logic                   sel_sample;
    logic                   sel_id;
    logic                   sel_bsr;
    logic                   sel_bypass;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ir_shift <= IR_CAPTURE;
        end else if (tck_rise && state == CAP_IR) begin
            ir_shift <= IR_CAPTURE;
        end else if (tck_rise && state == SH_IR) begin
            ir_shift <= {tdi_s, ir_shift[IR_LEN-1:1]};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ir <= IR_IDCODE;
        end else if (state == TLR) begin
            ir <= IR_IDCODE;
        end else if (tck_fall && state == UPD_IR) begin
            ir <= ir_shift;
        end
    end

    assign sel_extest = (ir == IR_EXTEST);
    assign sel_intest = (ir == IR_INTEST);
    assign sel_sample = (ir == IR_SAMPLE);
    assign sel_id     = (ir == IR_IDCODE);
    assign sel_bsr    = sel_extest | sel_intest | sel_sample;
    // every unlisted code, 3'h7 among them, falls through to bypass
    assign sel_bypass = ~(sel_bsr | sel_id);

    // ------------------------------------------------------------------
    // boundary-scan register
    // ------------------------------------------------------------------
    logic [CHAIN_LEN-1:0]   sys_in;
    logic [CHAIN_LEN-1:0]   sys_out;
    logic [CHAIN_LEN-1:0]   bsr;
    logic [CHAIN_LEN-1:0]   upd;

    // head first, tail last so address strobe sits next to the output
    assign sys_in = {head_sys_in, tail_sys_in};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bsr <= BSR_INIT;
        end else if (tck_rise && sel_bsr && state == CAP_DR) begin
            bsr <= sys_in;
        end else if (tck_rise && sel_bsr && state == SH_DR) begin
            bsr <= {tdi_s, bsr[CHAIN_LEN-1:1]};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            upd <= BSR_INIT;
        end else if (state == TLR) begin
            upd <= BSR_INIT;
        end else if (tck_fall && sel_bsr && state == UPD_DR) begin
            upd <= bsr;
        end
    end

    // data-in cells feed the core in internal test; drive and enable
    // cells feed the pads in external test; otherwise transparent
    genvar gi;
    generate
        for (gi = 0; gi < CHAIN_LEN; gi++) begin : g_cell
            logic test_drive;
            assign test_drive  = CELL_IS_INPUT[gi] ? sel_intest : sel_extest;
            assign sys_out[gi] = test_drive ? upd[gi] : sys_in[gi];
        end
    endgenerate

    assign head_sys_out = sys_out[CHAIN_LEN-1:TAIL_LEN];
    assign tail_sys_out = bst_tail_t'(sys_out[TAIL_LEN-1:0]);

    // ------------------------------------------------------------------
    // identification and bypass registers
    // ------------------------------------------------------------------
    localparam logic [ID_LEN-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED_ONE};

    logic [ID_LEN-1:0]      idr;
    logic                   bypass;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            idr <= ID_WORD;
        end else if (tck_rise && sel_id && state == CAP_DR) begin
            idr <= ID_WORD;
        end else if (tck_rise && sel_id && state == SH_DR) begin
            idr <= {tdi_s, idr[ID_LEN-1:1]};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bypass <= 1'h0;
        end else if (tck_rise && sel_bypass && state == CAP_DR) begin
            bypass <= 1'h0;
        end else if (tck_rise && sel_bypass && state == SH_DR) begin
            bypass <= tdi_s;
        end
    end

    // ------------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------------
    logic                   dr_out;

    assign dr_out = sel_bsr ? bsr[0] : (sel_id ? idr[0] : bypass);

    // falling edge launch gives the tester a half period of setup, less the synchroniser latency
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tdo    <= 1'h0;
            tdo_oe <= 1'h0;
        end else if (tck_fall) begin
            case (state)
                SH_DR: begin
                    tdo    <= dr_out;
                    tdo_oe <= 1'h1;
                end
                SH_IR: begin
                    tdo    <= ir_shift[0];
                    tdo_oe <= 1'h1;
                end
                default: begin
                    tdo_oe <= 1'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_cap_id;
        tck_rise && sel_id && state == CAP_DR;
    endsequence

    sequence s_shift_bsr;
        tck_rise && sel_bsr && state == SH_DR;
    endsequence

    sequence s_update_bsr;
        tck_fall && sel_bsr && state == UPD_DR;
    endsequence

    chk_reset_selects_id: assert property (state == TLR |=> ir == IR_IDCODE)
        else $error("reset state did not select identification");

    chk_capture_ir_code: assert property (tck_rise && state == CAP_IR |=> ir_shift == 3'h1)
        else $error("capture-ir did not load internal test code");

    chk_ir_lsb_first: assert property (tck_rise && state == SH_IR |=>
        ir_shift == {$past(tdi_s), $past(ir_shift[2:1])})
        else $error("instruction shift order wrong");

    chk_bypass_one_stage: assert property (tck_rise && sel_bypass && state == SH_DR |=>
        bypass == $past(tdi_s))
        else $error("bypass stage did not take serial input");

    chk_bsr_shift_len: assert property (s_shift_bsr |=>
        bsr[157] == $past(tdi_s) && bsr[156:0] == $past(bsr[157:1]))
        else $error("boundary chain shift broken");

    chk_update_from_shift: assert property (s_update_bsr |=> upd == $past(bsr))
        else $error("update stage did not take shifted vector");

    chk_id_word_loaded: assert property (s_cap_id |=> idr == ID_WORD && idr[0] == 1'h1)
        else $error("identification word not captured");

    chk_extest_drives_pins: assert property (sel_extest |->
        ((sys_out ^ upd) & ~CELL_IS_INPUT) == '0 && ((sys_out ^ sys_in) & CELL_IS_INPUT) == '0)
        else $error("external test pin drive wrong");

    chk_intest_feeds_core: assert property (sel_intest |->
        ((sys_out ^ upd) & CELL_IS_INPUT) == '0)
        else $error("internal test core inputs not from cells");

    chk_sample_transparent: assert property (sel_sample |-> sys_out == sys_in)
        else $error("sample disturbed the pins");

    chk_tdo_on_fall: assert property ($changed(tdo) |-> $past(tck_fall))
        else $error("serial output changed off the falling edge");

    chk_tdo_off_idle: assert property (tck_fall && state != SH_DR && state != SH_IR |=> !tdo_oe)
        else $error("serial output driven outside shift");

    chk_tail_reset_zero: assert property (state == TLR |=> upd[31:0] == 32'h0)
        else $error("tail cells not initialised to zero");

endmodule : bst_tap
`default_nettype wire

// >>> bst_tester.sv
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
    output var  logic tck,
    output var  logic tms,
    output var  logic tdi,
    output var  logic trst_n,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    // ------------------------------------------------------------------
    // link timing: 125 ns test clock, still between frames
    // ------------------------------------------------------------------
    localparam realtime HALF = 62.5;
    int                 oe_misses;

    initial begin
        tck       = 1'h0;
        tms       = 1'h1;
        tdi       = 1'h1;
        trst_n    = 1'h1;
        oe_misses = 0;
    end

    // ------------------------------------------------------------------
    // one test clock, tdo taken at the rise
    // ------------------------------------------------------------------
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #(HALF);
        tck = 1'h1;          // controller steps on this rise
        q   = tdo;
        #(HALF);
        tck = 1'h0;
    endtask : step

    // tms sequence lsb first; tdi released to its pull-up level
    task automatic walk(input logic [7:0] seq, input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            step(seq[i], 1'h1, q);
        end
    endtask : walk

    task automatic tms_reset();
        walk(8'hFF, 5);      // five ones reach test-logic-reset
    endtask : tms_reset

    task automatic pulse_trst();
        trst_n = 1'h0;
        #500;
        trst_n = 1'h1;
        #200;
    endtask : pulse_trst

    // from run-test-idle: select, capture, shift n bits, update, idle
    task automatic scan(input logic ir, input int n, input logic [199:0] din, output logic [199:0] dout);
        logic q;
        dout = '0;
        walk(ir ? 8'h03 : 8'h01, ir ? 2 : 1);
        walk(8'h00, 2);      // capture then shift
        for (int i = 0; i < n; i++) begin
            step(logic'(i == n - 1), din[i], q); // lsb first
            dout[i] = q;
            if (tdo_oe !== 1'h1) begin
                oe_misses++;
            end
        end
        walk(8'h01, 2);
    endtask : scan
endmodule : bst_tester
`default_nettype wire

// >>> bst_tap_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bst_tap_bench
    import bst_pkg::*;
;
    localparam logic [3:0]  VER   = 4'h9;     // arbitrary value
    localparam logic [15:0] PART  = 16'h3C5A; // arbitrary value
    localparam logic [10:0] MAKER = 11'h155;  // arbitrary value
    localparam logic [CHAIN_LEN-1:0] INIT = {HEAD_INIT, 32'h0};

    logic                 clock, rst_n, tck, tms, tdi, trst_n, tdo, tdo_oe;
    wire                  tdo_pin;
    logic [HEAD_LEN-1:0]  head_in, head_out;
    bst_tail_t            tail_in, tail_out;
    logic [CHAIN_LEN-1:0] sys, upd;
    logic [199:0]         din, dout;
    logic [2:0]           code;
    int                   mismatches, n_tests;

    assign tdo_pin = tdo_oe ? tdo : 1'hz;

    bst_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) u_dut (
        .clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo(tdo), .tdo_oe(tdo_oe), .head_sys_in(head_in), .head_sys_out(head_out),
        .tail_sys_in(tail_in), .tail_sys_out(tail_out));

    bst_tester u_tester (
        .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo_pin), .tdo_oe(tdo_oe));

    initial begin
        clock = 1'h0;
    end
    always #5 clock = ~clock;

    // ------------------------------------------------------------------
    // expectations and checks
    // ------------------------------------------------------------------
    function automatic logic [199:0] rnd();
        logic [223:0] r;
        r = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
        return r[199:0];
    endfunction : rnd

    function automatic logic [CHAIN_LEN-1:0] exp_pins(input logic [2:0] c, input logic [CHAIN_LEN-1:0] u,
                                                     input logic [CHAIN_LEN-1:0] s);
        case (c)
            IR_EXTEST: return (CELL_IS_INPUT & s) | (~CELL_IS_INPUT & u);
            IR_INTEST: return (CELL_IS_INPUT & u) | (~CELL_IS_INPUT & s);
            default:   return s;
        endcase
    endfunction : exp_pins

    task automatic check(input string what, input logic [199:0] exp, input logic [199:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic set_sys();
        logic [199:0] r;
        r = rnd();
        @(posedge clock);
        #1;
        {head_in, tail_in} = r[CHAIN_LEN-1:0];
        sys = r[CHAIN_LEN-1:0];
    endtask : set_sys

    task automatic check_pins(input string what, input logic [2:0] c, input logic [CHAIN_LEN-1:0] u);
        repeat (2) @(posedge clock);
        // look off the edge, and leave the next tester call off it too
        #1;
        check(what, 200'(exp_pins(c, u, sys)), 200'({head_out, tail_out}));
    endtask : check_pins

    task automatic read_id();
        u_tester.walk(8'h00, 1);
        u_tester.scan(1'h0, 32, '0, dout); // tms 0,1,0,0 from reset
        check("idcode", {168'h0, VER, PART, MAKER, 1'h1}, dout);
        check("tdo enable idle", 200'h0, 200'(tdo_oe));
    endtask : read_id

    task automatic final_report();
        if (mismatches == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        mismatches = 0;
        n_tests    = 0;
        rst_n      = 1'h0;
        head_in    = '0;
        tail_in    = '0;
        sys        = '0;
        upd        = INIT;
        void'($urandom(42));
        repeat (5) @(posedge clock);
        #1;
        rst_n = 1'h1;
        repeat (8) @(posedge clock);
        #1;
        read_id();
        // every code, awkward bypass-like ones included
        for (int c = 0; c < 8; c++) begin
            code = 3'(c);
            set_sys();
            u_tester.scan(1'h1, 3, {197'h0, code}, dout);
            check("ir capture", 200'h1, dout);
            if (code == IR_EXTEST) begin
                check_pins("extest initial", code, INIT);
            end
            din = rnd();
            u_tester.scan(1'h0, 166, din, dout);
            if (code inside {IR_EXTEST, IR_INTEST, IR_SAMPLE}) begin
                check("chain out", {34'h0, din[7:0], sys}, dout);
                upd = din[165:8];
            end else if (code == IR_IDCODE) begin
                check("idcode", {168'h0, VER, PART, MAKER, 1'h1}, {168'h0, dout[31:0]});
            end else begin
                check("bypass", {34'h0, din[164:0], 1'h0}, dout);
            end
            set_sys();
            check_pins("pins", code, upd);
        end
        // test reset, then internal test picked by capture alone
        u_tester.pulse_trst();
        u_tester.walk(8'h00, 1);
        u_tester.walk(8'h1B, 6);
        set_sys();
        check_pins("intest by capture", IR_INTEST, INIT);
        u_tester.tms_reset();
        read_id();
        check("tdo enable in shift", 200'h0, 200'(u_tester.oe_misses));
        final_report();
    end

    // hang guard, about three times the expected run
    initial begin
        #600000;
        mismatches++;
        final_report();
    end
endmodule : bst_tap_bench
`default_nettype wire
